// File: hw/adc_seq_pkg.sv
package adc_seq_pkg;

	// register word indexes on the bus (byte offset is index times 4)
	localparam logic [2:0] IDX_CTRL0 = 3'h0;
	localparam logic [2:0] IDX_CTRL1 = 3'h1;
	localparam logic [2:0] IDX_FMT = 3'h2;
	localparam logic [2:0] IDX_TRIG = 3'h3;
	localparam logic [2:0] IDX_RES_HI = 3'h4;
	localparam logic [2:0] IDX_RES_LO = 3'h5;
	localparam logic [2:0] IDX_WAKE = 3'h6;
	localparam logic [31:0] OFS_CTRL0 = 32'h0000_0000;
	localparam logic [31:0] OFS_WAKE = 32'h0000_0018;
	localparam logic [31:0] MAP_LIMIT = 32'h0000_001c;

	// field positions
	localparam int B_POWER = 7;
	localparam int B_GO = 6;
	localparam int B_DONE = 5;
	localparam int B_REF_OUT = 3;
	localparam int B_REF_SRC = 2;
	localparam int B_LEN = 7;
	localparam int B_ALIGN = 6;
	localparam int B_WAKE_EN = 7;
	localparam int B_WAKE_FLAG = 6;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;
	localparam logic [4:0] TRIG_SW_ONLY = 5'h00;
	localparam logic [7:0] FMT_RST = 8'h00;
	localparam logic [7:0] TRIG_RST = 8'h00;

	// converter-facing controls, one bundle
	typedef struct packed {
		logic power;
		logic ref_out;
		logic ref_src;
		logic [1:0] ref_lvl;
		logic [1:0] int_sel;
		logic [3:0] ext_sel;
	} analog_ctrl_t;

	// reference level resets to 2 V code, all else off
	localparam analog_ctrl_t ANALOG_RST = 11'h0c0;

	typedef enum logic [0:0] {
		CONV_IDLE = 1'b0,
		CONV_BUSY = 1'b1
	} conv_state_t;

	// last count of the oscillator divider: divide by 2,4,6,8,12,16,24,32
	function automatic logic [4:0] div_last(input logic [2:0] code);
		unique case (code)
			3'h0: div_last = 5'h01;
			3'h1: div_last = 5'h03;
			3'h2: div_last = 5'h05;
			3'h3: div_last = 5'h07;
			3'h4: div_last = 5'h0b;
			3'h5: div_last = 5'h0f;
			3'h6: div_last = 5'h17;
			3'h7: div_last = 5'h1f;
		endcase
	endfunction : div_last

	// last converter clock of a conversion: 22, 19 or 15 clocks
	function automatic logic [4:0] conv_last(input logic [2:0] code);
		unique case (code)
			3'h0: conv_last = 5'h15;
			3'h1, 3'h2: conv_last = 5'h12;
			default: conv_last = 5'h0e;
		endcase
	endfunction : conv_last

endpackage : adc_seq_pkg

// File: hw/adc_sequencing_control.sv
// Contract
// - power bit off forced in power-down
// - go starts; hardware clears; zero aborts
// - done flag set blocks new start
// - done flag set at end; software clears
// - reference output drives reference pin
// - reference source selects internal or external
// - reference level field, resets to 11
// - internal input field selects internal channel
// - external field selects numbered analog input
// - length bit picks 12 or 10 bits
// - 12-bit packing under alignment bit
// - 10-bit packing under alignment bit
// - timing field gives 22/19/15 clocks
// - clock field divides oscillator 2..32
// - reserved bits read zero, ignore writes; TRIG bits 7:5 are stored and read back as written
// - low wake pin in sleep sets flag
// - trigger field zero means go only
// - triggers ignored while converting
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
module adc_sequencing_control (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic power_down_state_i,
	input wire logic idle_state_i,
	input wire logic wake_pin_low_i,
	input wire logic [11:0] conv_data_i,
	input wire logic [31:1] trigger_event_i,
	output adc_seq_pkg::analog_ctrl_t analog_ctrl_o,
	output logic conversion_go_o,
	output logic conv_clk_tick_o,
	output logic conversion_done_flag_o,
	output logic key_wake_flag_o,
	output logic wake_request_o
);

	adc_seq_pkg::conv_state_t state;
	adc_seq_pkg::conv_state_t next_state;
	logic dp_write;
	logic [2:0] dp_idx;
	logic [7:0] fmt;
	logic [7:0] trig;
	logic [7:0] result_high_byte;
	logic [7:0] result_low_byte;
	logic wake_en;
	logic [4:0] div_cnt;
	logic [4:0] div_lat;
	logic [4:0] conv_cnt;
	logic [4:0] len_lat;
	logic busy;
	logic tick;
	logic finish;
	logic abort;
	logic start;
	logic hw_trig;
	logic ap_take;
	logic ap_mapped;
	logic [2:0] ap_idx;
	logic [7:0] wdata;
	logic wr_ctrl0;
	logic wake_set;
	logic [7:0] next_hi;
	logic [7:0] next_lo;
	logic [7:0] rd_byte;

	// ---------------- bus slave ----------------
	assign ap_take = hsel_i && hready_i && htrans_i[1] && hsize_i == adc_seq_pkg::HSIZE_WORD;
	assign ap_mapped = haddr_i < adc_seq_pkg::MAP_LIMIT && haddr_i[1:0] == 2'h0;
	assign ap_idx = haddr_i[4:2];
	assign wdata = hwdata_i[7:0];
	assign wr_ctrl0 = dp_write && dp_idx == adc_seq_pkg::IDX_CTRL0;

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			dp_write <= 1'b0;
			dp_idx <= 3'h0;
		end
		else
		begin
			dp_write <= ap_take && hwrite_i && ap_mapped;
			dp_idx <= ap_idx;
		end
	end

	always_comb
	begin
		rd_byte = 8'h00;
		if (ap_mapped)
		begin
			unique case (ap_idx)
				adc_seq_pkg::IDX_CTRL0: rd_byte = {analog_ctrl_o.power, busy,
					conversion_done_flag_o, 1'b0, analog_ctrl_o.ref_out,
					analog_ctrl_o.ref_src, analog_ctrl_o.ref_lvl};
				adc_seq_pkg::IDX_CTRL1: rd_byte = {analog_ctrl_o.int_sel, 2'h0,
					analog_ctrl_o.ext_sel};
				adc_seq_pkg::IDX_FMT: rd_byte = fmt;
				adc_seq_pkg::IDX_TRIG: rd_byte = trig;
				adc_seq_pkg::IDX_RES_HI: rd_byte = result_high_byte;
				adc_seq_pkg::IDX_RES_LO: rd_byte = result_low_byte;
				adc_seq_pkg::IDX_WAKE: rd_byte = {wake_en, key_wake_flag_o, 6'h00};
				default: rd_byte = 8'h00;
			endcase
		end
	end

	// read data captured in the address phase: zero wait states, always okay
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			hrdata_o <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o <= adc_seq_pkg::HRESP_OKAY;
		end
		else
		begin
			hrdata_o <= (ap_take && !hwrite_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o <= adc_seq_pkg::HRESP_OKAY;
		end
	end

	// ---------------- configuration ----------------
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			analog_ctrl_o <= adc_seq_pkg::ANALOG_RST;
		else
		begin
			if (wr_ctrl0)
			begin
				analog_ctrl_o.ref_out <= wdata[adc_seq_pkg::B_REF_OUT];
				analog_ctrl_o.ref_src <= wdata[adc_seq_pkg::B_REF_SRC];
				analog_ctrl_o.ref_lvl <= wdata[1:0];
			end
			if (dp_write && dp_idx == adc_seq_pkg::IDX_CTRL1)
			begin
				analog_ctrl_o.int_sel <= wdata[7:6];
				analog_ctrl_o.ext_sel <= wdata[3:0];
			end
			// power-down overrides whatever software asked for
			if (power_down_state_i)
				analog_ctrl_o.power <= 1'b0;
			else if (wr_ctrl0)
				analog_ctrl_o.power <= wdata[adc_seq_pkg::B_POWER];
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			fmt <= adc_seq_pkg::FMT_RST;
			trig <= adc_seq_pkg::TRIG_RST;
		end
		else
		begin
			if (dp_write && dp_idx == adc_seq_pkg::IDX_FMT)
				fmt <= wdata;
			if (dp_write && dp_idx == adc_seq_pkg::IDX_TRIG)
				trig <= wdata;
		end
	end

	// ---------------- conversion sequencing ----------------
	assign busy = state == adc_seq_pkg::CONV_BUSY;
	assign hw_trig = trig[4:0] != adc_seq_pkg::TRIG_SW_ONLY && trigger_event_i[trig[4:0]];
	// a busy converter or a pending flag swallows every start request
	assign start = !busy && !conversion_done_flag_o
		&& ((wr_ctrl0 && wdata[adc_seq_pkg::B_GO]) || hw_trig);
	assign tick = busy && div_cnt == div_lat;
	assign finish = tick && conv_cnt == len_lat;
	assign abort = busy && wr_ctrl0 && !wdata[adc_seq_pkg::B_GO] && !finish;

	always_comb
	begin
		next_state = state;
		unique case (state)
			adc_seq_pkg::CONV_IDLE: if (start) next_state = adc_seq_pkg::CONV_BUSY;
			adc_seq_pkg::CONV_BUSY: if (finish || abort) next_state = adc_seq_pkg::CONV_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			state <= adc_seq_pkg::CONV_IDLE;
		else
			state <= next_state;
	end

	// divider and length are frozen at start so mid-run edits cannot stretch a run
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			div_cnt <= 5'h00;
			conv_cnt <= 5'h00;
			div_lat <= 5'h01;
			len_lat <= 5'h15;
			conv_clk_tick_o <= 1'b0;
		end
		else
		begin
			conv_clk_tick_o <= tick;
			if (start)
			begin
				div_cnt <= 5'h00;
				conv_cnt <= 5'h00;
				div_lat <= adc_seq_pkg::div_last(fmt[2:0]);
				len_lat <= adc_seq_pkg::conv_last(fmt[5:3]);
			end
			else if (busy)
			begin
				div_cnt <= tick ? 5'h00 : div_cnt + 5'h01;
				if (tick)
					conv_cnt <= conv_cnt + 5'h01;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			conversion_go_o <= 1'b0;
		else
			conversion_go_o <= next_state == adc_seq_pkg::CONV_BUSY;
	end

	// set beats a same-cycle clear; writing 1 never sets it
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			conversion_done_flag_o <= 1'b0;
		else if (finish)
			conversion_done_flag_o <= 1'b1;
		else if (wr_ctrl0 && !wdata[adc_seq_pkg::B_DONE])
			conversion_done_flag_o <= 1'b0;
	end

	// ---------------- result packing ----------------
	always_comb
	begin
		next_hi = 8'h00;
		next_lo = 8'h00;
		unique case ({fmt[adc_seq_pkg::B_LEN], fmt[adc_seq_pkg::B_ALIGN]})
			2'b00:
			begin
				next_hi = conv_data_i[11:4];
				next_lo = {4'h0, conv_data_i[3:0]};
			end
			2'b01:
			begin
				next_hi = {4'h0, conv_data_i[11:8]};
				next_lo = conv_data_i[7:0];
			end
			2'b10:
			begin
				next_hi = conv_data_i[11:4];
				next_lo = {6'h00, conv_data_i[3:2]};
			end
			2'b11:
			begin
				next_hi = {6'h00, conv_data_i[11:10]};
				next_lo = conv_data_i[9:2];
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			result_high_byte <= 8'h00;
			result_low_byte <= 8'h00;
		end
		else if (finish)
		begin
			result_high_byte <= next_hi;
			result_low_byte <= next_lo;
		end
	end

	// ---------------- key wake ----------------
	assign wake_set = (idle_state_i || power_down_state_i) && wake_en && wake_pin_low_i;

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			wake_en <= 1'b0;
			key_wake_flag_o <= 1'b0;
			wake_request_o <= 1'b0;
		end
		else
		begin
			wake_request_o <= wake_set;
			if (dp_write && dp_idx == adc_seq_pkg::IDX_WAKE)
				wake_en <= wdata[adc_seq_pkg::B_WAKE_EN];
			if (wake_set)
				key_wake_flag_o <= 1'b1;
			else if (dp_write && dp_idx == adc_seq_pkg::IDX_WAKE
				&& !wdata[adc_seq_pkg::B_WAKE_FLAG])
				key_wake_flag_o <= 1'b0;
		end
	end

	// ---------------- checks ----------------
	logic [5:0] gap_cnt;
	logic [4:0] tick_seen;

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			gap_cnt <= 6'h00;
			tick_seen <= 5'h00;
		end
		else
		begin
			gap_cnt <= (start || tick) ? 6'h00 : gap_cnt + 6'h01;
			if (start)
				tick_seen <= 5'h00;
			else if (tick)
				tick_seen <= tick_seen + 5'h01;
		end
	end

	sequence seq_sw_start;
		!busy && !conversion_done_flag_o && wr_ctrl0 && wdata[adc_seq_pkg::B_GO];
	endsequence

	sequence seq_running;
		conversion_go_o[*8];
	endsequence

	a_power_forced: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		power_down_state_i |=> !analog_ctrl_o.power)
		else $error("power bit not forced off in power-down");

	a_start_runs: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		seq_sw_start ##1 !abort |=> seq_running)
		else $error("conversion did not keep running after start");

	a_go_blocked: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(!busy && conversion_done_flag_o) |=> !conversion_go_o)
		else $error("conversion started while done flag set");

	a_flag_sticky: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		conversion_done_flag_o && !(wr_ctrl0 && !wdata[adc_seq_pkg::B_DONE])
		|=> conversion_done_flag_o)
		else $error("done flag lost without software clear");

	a_finish_effect: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		finish |=> conversion_done_flag_o && !conversion_go_o
		&& result_high_byte == $past(next_hi))
		else $error("end of conversion not handled in one cycle");

	a_length_count: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		finish |-> tick_seen == len_lat && len_lat inside {5'h15, 5'h12, 5'h0e})
		else $error("conversion length wrong");

	a_clock_divide: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		tick |-> gap_cnt == {1'b0, div_lat})
		else $error("converter clock period wrong");

	a_trig_ignored: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		busy && hw_trig && !finish && !abort |=> conversion_go_o && $stable(len_lat))
		else $error("trigger disturbed a running conversion");

	a_pack_twelve: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		finish && fmt[7:6] == 2'b00 |=> result_high_byte == $past(conv_data_i[11:4])
		&& result_low_byte[7:4] == 4'h0)
		else $error("12-bit left packing wrong");

	a_pack_ten: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		finish && fmt[7:6] == 2'b11 |=> result_low_byte == $past(conv_data_i[9:2])
		&& result_high_byte[7:2] == 6'h00)
		else $error("10-bit right packing wrong");

	a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		ap_take && !hwrite_i && haddr_i == adc_seq_pkg::OFS_CTRL0
		|=> hrdata_o[4] == 1'b0 && hrdata_o[31:8] == 24'h00_0000)
		else $error("reserved bits not zero");

	a_key_wake: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		wake_set |=> key_wake_flag_o && wake_request_o)
		else $error("key wake not flagged");

	a_wake_read: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		ap_take && !hwrite_i && haddr_i == adc_seq_pkg::OFS_WAKE
		|=> hrdata_o[adc_seq_pkg::B_WAKE_FLAG] == $past(key_wake_flag_o))
		else $error("wake flag read back wrong");

endmodule : adc_sequencing_control

// File: dv/conv_core_model.sv
// behavioural converter core: registers the analog level every cycle while a run is active
module conv_core_model (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic go_i,
	input wire logic [11:0] level_i,
	output logic [11:0] data_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// outside a run the sample is meaningless, so it churns every cycle
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			data_o <= 12'h000;
		else if (go_i)
			data_o <= level_i;
		else
			data_o <= ~data_o;
	end
endmodule : conv_core_model

// File: dv/adc_sequencing_control_tb.sv
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin $display("[ERR] %s exp %0h got %0h", nm, e, s); bad_count++; end end
module adc_sequencing_control_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pd = 1'b0, idle = 1'b0, pin = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0, k;
	logic [11:0] data, level = 12'h000;
	logic [31:1] trig = '0;
	logic [15:0] e16;
	logic hreadyout, hresp, go, tick, done, kwf, wreq;
	adc_seq_pkg::analog_ctrl_t actl;
	int bad_count = 0, n_tests = 0, cyc = 0, cnt, nt;
	int unsigned seed;

	always #20 clk = ~clk;

	adc_sequencing_control dut (.core_clk_i(clk), .rstn_i(rstn), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
		.power_down_state_i(pd), .idle_state_i(idle), .wake_pin_low_i(pin), .conv_data_i(data),
		.trigger_event_i(trig), .analog_ctrl_o(actl), .conversion_go_o(go),
		.conv_clk_tick_o(tick), .conversion_done_flag_o(done), .key_wake_flag_o(kwf),
		.wake_request_o(wreq));

	conv_core_model core (.core_clk_i(clk), .rstn_i(rstn), .go_i(go), .level_i(level),
		.data_o(data));

	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	// longest path is eight runs of at most 704 cycles plus the abort wait
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			bad_count++;
			report_and_stop();
		end
	end

	function automatic int dlen(input logic [2:0] c);
		int t[8] = '{2, 4, 6, 8, 12, 16, 24, 32};
		return t[c];
	endfunction : dlen

	function automatic int nlen(input logic [2:0] c);
		return (c == 3'h0) ? 22 : (c < 3'h3) ? 19 : 15;
	endfunction : nlen

	function automatic logic [15:0] pk(input logic [11:0] d, input logic l, input logic a);
		case ({l, a})
			2'b00: return {d[11:4], 4'h0, d[3:0]};
			2'b01: return {4'h0, d[11:8], d[7:0]};
			2'b10: return {d[11:4], 6'h00, d[3:2]};
			default: return {6'h00, d[11:10], d[9:2]};
		endcase
	endfunction : pk

	// single word transfer; hready and read data are sampled at the rising edge itself
	task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= adc_seq_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= adc_seq_pkg::HSIZE_WORD;
		@(posedge clk);
		while (hreadyout !== 1'b1)
			@(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		@(posedge clk);
		while (hreadyout !== 1'b1)
			@(posedge clk);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		bus(a, 1'b1, d);
	endtask : wr

	task automatic chk_rd(input logic [31:0] a, input logic [7:0] e);
		bus(a, 1'b0, 8'h00);
		`CHK("read data", {24'h000000, e}, rd)
		`CHK("response", adc_seq_pkg::HRESP_OKAY, hresp)
	endtask : chk_rd

	// counts edges leaving go high, the calling edge included, and converter ticks seen
	task automatic run_len(input int exp_cycles, input int exp_ticks);
		cnt = 1;
		nt = 0;
		forever
		begin
			@(posedge clk);
			#1;
			if (tick === 1'b1)
				nt++;
			if (go !== 1'b1)
				break;
			cnt++;
		end
		`CHK("run cycles", exp_cycles, cnt)
		`CHK("converter ticks", exp_ticks, nt)
	endtask : run_len

	initial
	begin
		seed = $urandom(72);
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		#1;
		`CHK("analog reset", 11'h0c0, actl)
		chk_rd(32'h0, 8'h03);
		for (int a = 1; a < 7; a++)
			chk_rd(32'(a * 4), 8'h00);
		wr(32'h4, 8'hff);
		chk_rd(32'h4, 8'hcf);
		`CHK("channels", 6'h3f, actl[5:0])
		wr(32'h4, 8'h03);
		#1;
		`CHK("external input", 4'h3, actl.ext_sel)
		wr(32'h0, 8'h1b);
		chk_rd(32'h0, 8'h0b);
		`CHK("ref drive", 4'hb, actl[9:6])
		wr(32'h0, 8'h06);
		#1;
		`CHK("ref select", 4'h6, actl[9:6])
		wr(32'h10, 8'haa);
		chk_rd(32'h10, 8'h00);
		chk_rd(32'h40, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			k = i[2:0];
			level <= 12'($urandom);
			wr(32'h8, {k[1], k[0], k, ~k});
			e16 = pk(level, k[1], k[0]);
			wr(32'h0, 8'h40);
			run_len(nlen(k) * dlen(~k), nlen(k));
			`CHK("done set", 1'b1, done)
			chk_rd(32'h10, e16[15:8]);
			chk_rd(32'h14, e16[7:0]);
			chk_rd(32'h0, 8'h20);
			wr(32'h0, 8'h60);
			repeat (3) @(posedge clk);
			#1;
			`CHK("blocked start", 1'b0, go)
			wr(32'h0, 8'h00);
			#1;
			`CHK("done cleared", 1'b0, done)
		end
		wr(32'h8, 8'h3f);
		level <= ~level;
		wr(32'h0, 8'h40);
		repeat (20) @(posedge clk);
		wr(32'h0, 8'h00);
		repeat (500) @(posedge clk);
		#1;
		`CHK("abort go", 1'b0, go)
		`CHK("abort done", 1'b0, done)
		chk_rd(32'h14, e16[7:0]);
		wr(32'h8, 8'h38);
		wr(32'hc, 8'h05);
		level <= 12'($urandom);
		trig[5] <= 1'b1;
		@(posedge clk);
		trig[5] <= 1'b0;
		repeat (10) @(posedge clk);
		trig[5] <= 1'b1;
		@(posedge clk);
		trig[5] <= 1'b0;
		run_len(19, 10);
		`CHK("trigger done", 1'b1, done)
		wr(32'h0, 8'h00);
		wr(32'hc, 8'h00);
		trig <= '1;
		@(posedge clk);
		trig <= '0;
		repeat (3) @(posedge clk);
		#1;
		`CHK("software only", 1'b0, go)
		wr(32'h18, 8'h80);
		wr(32'h0, 8'h80);
		pd <= 1'b1;
		pin <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		`CHK("power forced", 1'b0, actl.power)
		`CHK("wake flag", 1'b1, kwf)
		`CHK("wake request", 1'b1, wreq)
		chk_rd(32'h0, 8'h00);
		chk_rd(32'h18, 8'hc0);
		pd <= 1'b0;
		pin <= 1'b0;
		wr(32'h18, 8'h00);
		#1;
		`CHK("wake cleared", 1'b0, kwf)
		wr(32'h18, 8'h80);
		idle <= 1'b1;
		pin <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		`CHK("idle wake flag", 1'b1, kwf)
		`CHK("idle wake request", 1'b1, wreq)
		report_and_stop();
	end
endmodule : adc_sequencing_control_tb
